// *** hdl/saverb_map.vh ***
/*
 * Constants for the sample averager and record builder: clock and conversion
 * timing, channel counts and the controller's one-hot state codes.
 * Assumes a single 20 MHz system clock.
 */
`ifndef SAVERB_MAP_VH
`define SAVERB_MAP_VH

// Clock and conversion timing
`define SAVERB_CLK_PERIOD_NS  50
`define SAVERB_CONV_PERIOD_NS 4000
`define SAVERB_CONV_PERIOD_US 4
`define SAVERB_NS_PER_US      1000
`define SAVERB_CONV_CYCLES    (`SAVERB_CONV_PERIOD_NS / `SAVERB_CLK_PERIOD_NS)
`define SAVERB_US_CYCLES      (`SAVERB_NS_PER_US / `SAVERB_CLK_PERIOD_NS)
`define SAVERB_CONV_CNT_W     7
`define SAVERB_US_CNT_W       5

// Channel counts
`define SAVERB_N_CUR          4
`define SAVERB_N_AUX_IN       2
`define SAVERB_N_AUX_OUT      4
`define SAVERB_N_ADC          6
`define SAVERB_SEQ_W          8

// Controller states
`define SAVERB_ST_WAIT        3'h1
`define SAVERB_ST_DIV         3'h2
`define SAVERB_ST_EMIT        3'h4

`endif

// *** hdl/saverb_buf.v ***
/*
 * Two-entry buffer with valid and ready on both sides; read data come
 * straight from the head register.
 * Assumes both sides run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module saverb_buf #(
    parameter W = 8
) (
    input  wire         ref_clk_i,   // System clock
    input  wire         rstn_i,      // Async reset, active low
    input  wire         in_valid_i,  // Word offered
    output wire         in_ready_o,  // Room for a word
    input  wire [W-1:0] in_data_i,   // Word in
    output wire         out_valid_o, // Word held
    input  wire         out_ready_i, // Receiver takes the word
    output wire [W-1:0] out_data_o   // Head word
);

    reg  [W-1:0] d0_q;
    reg  [W-1:0] d1_q;
    reg  [1:0]   cnt_q;
    wire         push;
    wire         pop;

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = d0_q;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            d0_q  <= {W{1'b0}};
            d1_q  <= {W{1'b0}};
            cnt_q <= 2'h0;
        end else begin
            if (push && ((cnt_q == 2'h0) || ((cnt_q == 2'h1) && pop))) begin
                d0_q <= in_data_i;
            end else if (pop) begin
                d0_q <= d1_q;
            end
            if (push && (cnt_q == 2'h1) && !pop) begin
                d1_q <= in_data_i;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end

endmodule // saverb_buf

`default_nettype wire

// *** hdl/saverb_top.v ***
/*
 * Sample averager and record builder: paces ADC conversions, sums them over
 * the integration time, averages per channel and emits one reading record.
 * Assumes the ADC interface and control inputs are synchronous to ref_clk_i.
 */
// Summary of operation
// RULE_01 - One record holds all channels taken over the same interval.
// RULE_02 - One reading is emitted at the end of each integration period; if the controller is not idle it is dropped and rec_lost_o pulses.
// RULE_03 - Timestamp counts from acquisition start; first reading stamped zero.
// RULE_04 - Each reading carries a sequence count incrementing by one, modulo 256.
// RULE_05 - A channel's range flag is set if any summed conversion was over range.
// RULE_06 - Current values in amps, with optional sensor compensation, no filtering.
// RULE_07 - Each reading carries the two auxiliary analog input values.
// RULE_08 - Each reading carries the four auxiliary analog output settings.
// RULE_09 - Conversions per sample equal integration time times 250 kHz.
// RULE_10 - Accumulators are wide enough never to overflow or saturate.
// RULE_11 - Sum divided by count at period end; accumulator and flags then cleared.
// RULE_12 - Sequence count restarts at zero each acquisition and wraps 255 to 0.
`timescale 1ns/1ps
`default_nettype none
`include "saverb_map.vh"

module saverb_top #(
    parameter ADC_W  = 16,
    parameter CNT_W  = 24,
    parameter TIME_W = 26,
    parameter TS_W   = 32,
    parameter CUR_W  = 32
) (
    input  wire                                  ref_clk_i,       // 20 MHz clock
    input  wire                                  rstn_i,          // Async reset
    input  wire                                  acq_en_i,        // Acquisition run
    input  wire [TIME_W-1:0]                     integ_us_i,      // Integration, us
    input  wire                                  comp_en_i,       // Compensation on
    input  wire [`SAVERB_N_CUR*ADC_W-1:0]        comp_ofs_i,      // Comp. offsets
    input  wire [`SAVERB_N_CUR*ADC_W-1:0]        chan_gain_i,     // Amps per code
    input  wire [`SAVERB_N_AUX_OUT*ADC_W-1:0]    aux_out_set_i,   // Applied outputs
    output reg                                   adc_convst_o,    // Start conversion
    input  wire                                  adc_valid_i,     // Results valid
    input  wire [`SAVERB_N_ADC*ADC_W-1:0]        adc_data_i,      // Signed results
    input  wire [`SAVERB_N_CUR-1:0]              adc_ovr_i,       // Over range
    output wire                                  rec_valid_o,     // Record ready
    input  wire                                  rec_ready_i,     // Record taken
    output wire [TS_W-1:0]                       rec_ts_o,        // Timestamp, us
    output wire [`SAVERB_SEQ_W-1:0]              rec_seq_o,       // Sequence count
    output wire [`SAVERB_N_CUR-1:0]              rec_ovr_o,       // Range flags
    output wire [`SAVERB_N_CUR*CUR_W-1:0]        rec_cur_o,       // Currents
    output wire [`SAVERB_N_AUX_IN*ADC_W-1:0]     rec_aux_in_o,    // Aux inputs
    output wire [`SAVERB_N_AUX_OUT*ADC_W-1:0]    rec_aux_out_o,   // Aux outputs
    output reg                                   rec_lost_o       // Reading dropped
);

    localparam ACC_W  = ADC_W + CNT_W;
    localparam STEP_W = 8;
    localparam [TIME_W-1:0] CONV_US_IT = `SAVERB_CONV_PERIOD_US;
    localparam [TS_W-1:0]   CONV_US_TS = `SAVERB_CONV_PERIOD_US;
    localparam REC_W  = TS_W + `SAVERB_SEQ_W + `SAVERB_N_CUR + `SAVERB_N_CUR * CUR_W
                        + `SAVERB_N_AUX_IN * ADC_W + `SAVERB_N_AUX_OUT * ADC_W;

    reg                                 acq_q;
    reg  [`SAVERB_CONV_CNT_W-1:0]       conv_cnt_q;
    reg  [TS_W-1:0]                     period_ts_q;
    reg  [TS_W-1:0]                     snap_ts_q;
    reg  [CNT_W-1:0]                    n_q;
    reg  [CNT_W-1:0]                    n_snap_q;
    reg  [CNT_W-1:0]                    n_done_q;
    reg  [`SAVERB_N_CUR-1:0]            ovr_q;
    reg  [`SAVERB_N_CUR-1:0]            snap_ovr_q;
    reg  [`SAVERB_N_AUX_OUT*ADC_W-1:0]  snap_aout_q;
    reg  [`SAVERB_SEQ_W-1:0]            seq_q;
    reg  [`SAVERB_SEQ_W-1:0]            snap_seq_q;
    reg  [2:0]                          st_q;
    reg  [STEP_W-1:0]                   step_q;
    wire                                start;
    wire                                take;
    wire                                period_end;
    wire                                snap;
    wire [TIME_W-1:0]                   n_raw;
    wire [CNT_W-1:0]                    n_new;
    wire [TS_W-1:0]                     n_us;
    wire [`SAVERB_N_ADC*ADC_W-1:0]      avg_flat;
    wire [`SAVERB_N_CUR*CUR_W-1:0]      cur_flat;
    wire                                buf_ready;
    wire [REC_W-1:0]                    rec_in;
    wire [REC_W-1:0]                    rec_out;

    assign start = acq_en_i & ~acq_q;
    assign take  = adc_valid_i & acq_q & ~start;
    // RULE_02 period end
    assign period_end = take & ((n_done_q + {{(CNT_W-1){1'b0}}, 1'b1}) == n_q);
    assign snap       = period_end & (st_q == `SAVERB_ST_WAIT);

    // RULE_09 conversions per sample
    assign n_raw = integ_us_i / CONV_US_IT;
    assign n_new = (n_raw == {TIME_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : n_raw[CNT_W-1:0];
    assign n_us  = {{(TS_W-CNT_W){1'b0}}, n_q} * CONV_US_TS;

    // Conversion pacing: first start on the run edge, then one per conversion period
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acq_q        <= 1'b0;
            conv_cnt_q   <= {`SAVERB_CONV_CNT_W{1'b0}};
            adc_convst_o <= 1'b0;
        end else begin
            acq_q        <= acq_en_i;
            adc_convst_o <= acq_en_i && (start || (conv_cnt_q == `SAVERB_CONV_CYCLES - 1));
            if (start || !acq_en_i ||
                (conv_cnt_q == `SAVERB_CONV_CYCLES - 1)) begin
                conv_cnt_q <= {`SAVERB_CONV_CNT_W{1'b0}};
            end else begin
                conv_cnt_q <= conv_cnt_q + {{(`SAVERB_CONV_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Period bookkeeping, snapshots and controller
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            n_q         <= {{(CNT_W-1){1'b0}}, 1'b1};
            n_snap_q    <= {{(CNT_W-1){1'b0}}, 1'b1};
            n_done_q    <= {CNT_W{1'b0}};
            ovr_q       <= {`SAVERB_N_CUR{1'b0}};
            snap_ovr_q  <= {`SAVERB_N_CUR{1'b0}};
            period_ts_q <= {TS_W{1'b0}};
            snap_ts_q   <= {TS_W{1'b0}};
            snap_aout_q <= {(`SAVERB_N_AUX_OUT*ADC_W){1'b0}};
            seq_q       <= {`SAVERB_SEQ_W{1'b0}};
            snap_seq_q  <= {`SAVERB_SEQ_W{1'b0}};
            st_q        <= `SAVERB_ST_WAIT;
            step_q      <= {STEP_W{1'b0}};
            rec_lost_o  <= 1'b0;
        end else begin
            rec_lost_o <= period_end & ~snap;
            if (start) begin
                // RULE_12 restart count
                seq_q       <= {`SAVERB_SEQ_W{1'b0}};
                n_q         <= n_new;
                n_done_q    <= {CNT_W{1'b0}};
                ovr_q       <= {`SAVERB_N_CUR{1'b0}};
                period_ts_q <= {TS_W{1'b0}};
            end else if (period_end) begin
                // RULE_04 count every reading
                seq_q       <= seq_q + {{(`SAVERB_SEQ_W-1){1'b0}}, 1'b1};
                n_q         <= n_new;
                n_done_q    <= {CNT_W{1'b0}};
                // RULE_11 clear flags
                ovr_q       <= {`SAVERB_N_CUR{1'b0}};
                // RULE_03 next period start
                period_ts_q <= period_ts_q + n_us;
            end else if (take) begin
                n_done_q <= n_done_q + {{(CNT_W-1){1'b0}}, 1'b1};
                // RULE_05 sticky range flags
                ovr_q    <= ovr_q | adc_ovr_i;
            end
            if (snap) begin
                snap_ovr_q  <= ovr_q | adc_ovr_i;
                snap_ts_q   <= period_ts_q;
                snap_seq_q  <= seq_q;
                n_snap_q    <= n_q;
                // RULE_08 applied outputs
                snap_aout_q <= aux_out_set_i;
            end
            case (st_q)
                `SAVERB_ST_WAIT: begin
                    step_q <= {STEP_W{1'b0}};
                    if (snap) begin
                        st_q <= `SAVERB_ST_DIV;
                    end
                end
                `SAVERB_ST_DIV: begin
                    step_q <= step_q + {{(STEP_W-1){1'b0}}, 1'b1};
                    if (step_q == ACC_W - 1) begin
                        st_q <= `SAVERB_ST_EMIT;
                    end
                end
                `SAVERB_ST_EMIT: begin
                    if (buf_ready) begin
                        st_q <= `SAVERB_ST_WAIT;
                    end
                end
                default: begin
                    st_q <= `SAVERB_ST_WAIT;
                end
            endcase
        end
    end

    // Per-channel accumulate and restoring divide
    genvar k;
    generate
        for (k = 0; k < `SAVERB_N_ADC; k = k + 1) begin : g_ch
            reg  [ACC_W-1:0] acc_q;
            reg  [ACC_W-1:0] mag_q;
            reg  [ACC_W-1:0] quo_q;
            reg  [CNT_W:0]   rem_q;
            reg              neg_q;
            wire [ACC_W-1:0] sum;
            wire [CNT_W:0]   rem_sh;
            wire             fits;
            wire [ADC_W-1:0] q_lo;

            // RULE_10 deep accumulator
            assign sum    = acc_q + {{CNT_W{adc_data_i[(k+1)*ADC_W-1]}},
                                     adc_data_i[k*ADC_W +: ADC_W]};
            assign rem_sh = {rem_q[CNT_W-1:0], mag_q[ACC_W-1]};
            assign fits   = (rem_sh >= {1'b0, n_snap_q});
            assign q_lo   = quo_q[ADC_W-1:0];
            assign avg_flat[k*ADC_W +: ADC_W] = neg_q ? (~q_lo + {{(ADC_W-1){1'b0}}, 1'b1})
                                                      : q_lo;

            always @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    acc_q <= {ACC_W{1'b0}};
                    mag_q <= {ACC_W{1'b0}};
                    quo_q <= {ACC_W{1'b0}};
                    rem_q <= {(CNT_W+1){1'b0}};
                    neg_q <= 1'b0;
                end else begin
                    // RULE_01 all channels together
                    if (start || period_end) begin
                        acc_q <= {ACC_W{1'b0}};
                    end else if (take) begin
                        acc_q <= sum;
                    end
                    // RULE_11 average by count
                    if (snap) begin
                        neg_q <= sum[ACC_W-1];
                        mag_q <= sum[ACC_W-1] ? (~sum + {{(ACC_W-1){1'b0}}, 1'b1}) : sum;
                        quo_q <= {ACC_W{1'b0}};
                        rem_q <= {(CNT_W+1){1'b0}};
                    end else if (st_q == `SAVERB_ST_DIV) begin
                        mag_q <= {mag_q[ACC_W-2:0], 1'b0};
                        quo_q <= {quo_q[ACC_W-2:0], fits};
                        rem_q <= fits ? (rem_sh - {1'b0, n_snap_q}) : rem_sh;
                    end
                end
            end

            if (k < `SAVERB_N_CUR) begin : g_cur
                wire signed [ADC_W:0]   diff;
                wire signed [2*ADC_W:0] prod;
                // RULE_06 compensation and scaling
                assign diff = $signed({avg_flat[(k+1)*ADC_W-1], avg_flat[k*ADC_W +: ADC_W]})
                              - (comp_en_i ? $signed({comp_ofs_i[(k+1)*ADC_W-1],
                                                      comp_ofs_i[k*ADC_W +: ADC_W]})
                                           : $signed({(ADC_W+1){1'b0}}));
                assign prod = diff * $signed(chan_gain_i[k*ADC_W +: ADC_W]);
                assign cur_flat[k*CUR_W +: CUR_W] = prod[CUR_W-1:0];
            end
        end
    endgenerate

    // RULE_07 aux inputs in record
    assign rec_in = {snap_ts_q, snap_seq_q, snap_ovr_q, cur_flat,
                     avg_flat[`SAVERB_N_ADC*ADC_W-1:`SAVERB_N_CUR*ADC_W], snap_aout_q};

    saverb_buf #(
        .W (REC_W)
    ) u_buf (
        .ref_clk_i   (ref_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (st_q == `SAVERB_ST_EMIT),
        .in_ready_o  (buf_ready),
        .in_data_i   (rec_in),
        .out_valid_o (rec_valid_o),
        .out_ready_i (rec_ready_i),
        .out_data_o  (rec_out)
    );

    assign {rec_ts_o, rec_seq_o, rec_ovr_o, rec_cur_o, rec_aux_in_o, rec_aux_out_o} = rec_out;

endmodule // saverb_top

`default_nettype wire

// *** testbench/saverb_adc_model.sv ***
/*
 * Behavioural model of the six-lane parallel ADC that feeds the averager.
 * Assumes conversion start and results share the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module saverb_adc_model (
    input  wire logic        ref_clk_i,    // System clock
    input  wire logic        rstn_i,       // Async reset, active low
    input  wire logic        conv_start_i, // Start conversion
    input  wire logic [95:0] smp_a_i,      // Codes, even conversions
    input  wire logic [95:0] smp_b_i,      // Codes, odd conversions
    input  wire logic [3:0]  ovr_i,        // Over-range to report
    input  wire logic [5:0]  lat_i,        // Conversion time, cycles
    output var  logic        res_valid_o,  // Result strobe
    output var  logic [95:0] res_data_o,   // Result lanes
    output var  logic [3:0]  res_ovr_o     // Over-range lanes
);
    logic       busy_q;
    logic       tog_q;
    logic [5:0] wait_q;

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_q <= 1'b0;
            tog_q <= 1'b0;
            wait_q <= 6'h00;
            res_valid_o <= 1'b0;
            res_data_o <= '0;
            res_ovr_o <= 4'h0;
        end else begin
            res_valid_o <= 1'b0;
            // Lanes without a fresh result show junk
            res_data_o <= ~res_data_o;
            res_ovr_o <= ~res_ovr_o;
            if (conv_start_i) begin
                busy_q <= 1'b1;
                wait_q <= lat_i;
            end else if (busy_q && wait_q == 6'h00) begin
                busy_q <= 1'b0;
                tog_q <= ~tog_q;
                res_valid_o <= 1'b1;
                res_data_o <= tog_q ? smp_b_i : smp_a_i;
                res_ovr_o <= ovr_i;
            end else if (busy_q) begin
                wait_q <= wait_q - 6'h01;
            end
        end
    end
endmodule // saverb_adc_model

`default_nettype wire

// *** testbench/saverb_sva.sv ***
/*
 * Checker for the sample averager and record builder, bound to its top.
 * Assumes the ADC answers each conversion start well within 80 cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module saverb_sva #(
    parameter TIME_W = 26,
    parameter TS_W   = 32
) (
    input wire logic              ref_clk_i,    // Clock
    input wire logic              rstn_i,       // Reset
    input wire logic              acq_en_i,     // Run
    input wire logic [TIME_W-1:0] integ_us_i,   // Integration
    input wire logic              adc_convst_o, // Start
    input wire logic              adc_valid_i,  // Result
    input wire logic              rec_valid_o,  // Record held
    input wire logic              rec_ready_i,  // Record taken
    input wire logic [TS_W-1:0]   rec_ts_o,     // Timestamp
    input wire logic [7:0]        rec_seq_o,    // Sequence
    input wire logic              rec_lost_o    // Dropped
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic        acq_d_q, seen_q, fresh_q, lost_q;
    logic [6:0]  cyc_q;
    logic [7:0]  nxt_q;
    logic [23:0] vcnt_q;
    wire         take = rec_valid_o && rec_ready_i;
    wire         smp = adc_valid_i && acq_d_q;
    wire [23:0]  n_conv = (integ_us_i[TIME_W-1:2] == 0) ? 24'h0001 : integ_us_i[TIME_W-1:2];
    wire         pend = smp && (vcnt_q + 24'h0001 == n_conv);

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acq_d_q <= 1'b0;
            seen_q <= 1'b0;
            fresh_q <= 1'b0;
            lost_q <= 1'b0;
            cyc_q <= 7'h00;
            nxt_q <= 8'h00;
            vcnt_q <= 24'h0000;
        end else begin
            acq_d_q <= acq_en_i;
            seen_q <= acq_en_i && (seen_q || adc_convst_o);
            cyc_q <= adc_convst_o ? 7'h00 : cyc_q + 7'h01;
            vcnt_q <= (!acq_en_i || pend) ? 24'h0000 : vcnt_q + {23'h0, smp};
            if (acq_en_i && !acq_d_q) begin
                fresh_q <= 1'b1;
                lost_q <= 1'b0;
            end else begin
                if (rec_lost_o) lost_q <= 1'b1;
                if (take) fresh_q <= 1'b0;
                if (take) nxt_q <= rec_seq_o + 8'h01;
            end
        end
    end

    a_convst_first: assert property ($rose(acq_en_i) |=> adc_convst_o)
        else $error("no conversion start after run start");
    a_convst_period: assert property (adc_convst_o && seen_q |-> cyc_q == 7'h4F)
        else $error("conversion starts not 80 cycles apart");
    a_convst_idle: assert property (!acq_en_i ##1 !acq_en_i |-> !adc_convst_o)
        else $error("conversion start while stopped");
    a_rec_hold: assert property (rec_valid_o && !rec_ready_i |=>
        rec_valid_o && $stable(rec_seq_o) && $stable(rec_ts_o)) else $error("record not held");
    a_rec_latency: assert property (pend && !rec_valid_o |-> ##41 !rec_valid_o ##1 rec_valid_o)
        else $error("record not offered 42 cycles after period end");
    a_first_stamp: assert property (take && fresh_q |-> rec_ts_o == 0 && rec_seq_o == 8'h00)
        else $error("first reading not stamped zero");
    a_seq_step: assert property (take && !fresh_q && !lost_q |-> rec_seq_o == nxt_q)
        else $error("sequence count did not step by one");
    a_lost_cause: assert property (rec_lost_o |-> $past(pend))
        else $error("reading dropped without a period end");
endmodule // saverb_sva

bind saverb_top saverb_sva #(.TIME_W(TIME_W), .TS_W(TS_W)) u_saverb_sva (.ref_clk_i, .rstn_i,
    .acq_en_i, .integ_us_i, .adc_convst_o, .adc_valid_i, .rec_valid_o, .rec_ready_i,
    .rec_ts_o, .rec_seq_o, .rec_lost_o);

`default_nettype wire

// *** testbench/saverb_top_tb.sv ***
/*
 * Testbench for the sample averager and record builder.
 * Assumes the ADC model beside it and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module saverb_top_tb;
    logic         ref_clk_i, rstn_i, acq_en_i, comp_en_i, rec_ready_i;
    logic [25:0]  integ_us_i;
    logic [63:0]  comp_ofs_i, chan_gain_i, aux_out_set_i;
    logic [95:0]  smp_a, smp_b;
    logic [3:0]   ovr;
    logic [5:0]   lat;
    logic [7:0]   nseq;
    logic [31:0]  nts, step;
    wire          adc_convst_o, adc_valid_i, rec_valid_o, rec_lost_o;
    wire  [95:0]  adc_data_i;
    wire  [3:0]   adc_ovr_i, rec_ovr_o;
    wire  [31:0]  rec_ts_o, rec_aux_in_o;
    wire  [7:0]   rec_seq_o;
    wire  [127:0] rec_cur_o;
    wire  [63:0]  rec_aux_out_o;
    int           error_cnt, tests_run, lost_n, cyc, last_cyc;

    saverb_top u_saverb_top (.ref_clk_i, .rstn_i, .acq_en_i, .integ_us_i, .comp_en_i,
        .comp_ofs_i, .chan_gain_i, .aux_out_set_i, .adc_convst_o, .adc_valid_i,
        .adc_data_i, .adc_ovr_i, .rec_valid_o, .rec_ready_i, .rec_ts_o, .rec_seq_o,
        .rec_ovr_o, .rec_cur_o, .rec_aux_in_o, .rec_aux_out_o, .rec_lost_o);
    saverb_adc_model u_saverb_adc_model (.ref_clk_i, .rstn_i, .conv_start_i(adc_convst_o),
        .smp_a_i(smp_a), .smp_b_i(smp_b), .ovr_i(ovr), .lat_i(lat),
        .res_valid_o(adc_valid_i), .res_data_o(adc_data_i), .res_ovr_o(adc_ovr_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (rec_lost_o === 1'b1) lost_n <= lost_n + 1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic fail(input string m);
        error_cnt++;
        $display("wrong value at %0t ns: %s", $time, m);
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Average of two conversions, truncated toward zero
    function automatic int avg(input int k);
        return ($signed(smp_a[k*16+:16]) + $signed(smp_b[k*16+:16])) / 2;
    endfunction

    // Wait for one record, judge every field, then let it be taken
    task automatic get_rec(input logic [3:0] ov);
        int i;
        int k;
        int e;
        for (i = 0; i < 4000 && rec_valid_o !== 1'b1; i++) tick(1);
        if (rec_valid_o !== 1'b1) begin
            fail("no record");
            end_sim;
        end
        tests_run++;
        if (rec_seq_o !== nseq) fail("sequence count");
        if (rec_ts_o !== nts) fail("timestamp");
        if (rec_ovr_o !== ov) fail("range flags");
        if (rec_aux_out_o !== aux_out_set_i) fail("aux outputs");
        if (last_cyc != 0 && cyc - last_cyc != step * 20) fail("reading spacing");
        for (k = 0; k < 6; k++) begin
            e = avg(k);
            if (k < 4) e = e - (comp_en_i ? $signed(comp_ofs_i[k*16+:16]) : 0);
            if (k < 4) e = e * $signed(chan_gain_i[k*16+:16]);
            if (k < 4 && rec_cur_o[k*32+:32] !== e[31:0]) fail("current");
            if (k > 3 && rec_aux_in_o[(k-4)*16+:16] !== e[15:0]) fail("aux input");
        end
        nseq = nseq + 8'h01;
        nts = nts + step;
        last_cyc = cyc;
        tick(1);
    endtask

    task automatic run(input logic [25:0] it, input int n, input logic [5:0] l);
        acq_en_i = 1'b0;
        tick(300);
        integ_us_i = it;
        lat = l;
        step = {6'h0, it};
        nseq = 8'h00;
        nts = 32'h0000_0000;
        last_cyc = 0;
        acq_en_i = 1'b1;
        repeat (n) get_rec(4'h0);
    endtask

    task automatic s_comp;
        comp_en_i = 1'b1;
        aux_out_set_i = 64'h0F0F_A5A5_0001_FFFF;
        repeat (2) get_rec(4'h0);
    endtask

    task automatic s_ovr;
        int i;
        ovr = 4'h5;
        for (i = 0; i < 200 && adc_valid_i !== 1'b1; i++) tick(1);
        if (adc_valid_i !== 1'b1) fail("no conversion result");
        ovr = 4'h0;
        get_rec(4'h5);
        get_rec(4'h0);
    endtask

    task automatic s_stall;
        rec_ready_i = 1'b0;
        lost_n = 0;
        tick(900);
        tests_run++;
        if (lost_n == 0) fail("no dropped reading");
        rec_ready_i = 1'b1;
        repeat (3) begin
            last_cyc = 0;
            get_rec(4'h0);
        end
        nseq = nseq + lost_n[7:0];
        nts = nts + step * lost_n[31:0];
        last_cyc = 0;
        get_rec(4'h0);
    endtask

    initial begin
        rstn_i = 1'b0;
        acq_en_i = 1'b0;
        comp_en_i = 1'b0;
        rec_ready_i = 1'b1;
        integ_us_i = 26'h0008;
        comp_ofs_i = 64'h0002_0004_FFF0_0008;
        chan_gain_i = 64'h0003_FFFE_0010_0100;
        aux_out_set_i = 64'h1234_5678_9ABC_DEF0;
        smp_a = {16'hFFC4, 16'h0032, 16'h0007, 16'h0BB8, 16'hFF38, 16'h0064};
        smp_b = {16'hFFC6, 16'h0036, 16'h0009, 16'h0BBC, 16'hFF35, 16'h0066};
        ovr = 4'h0;
        lat = 6'h02;
        tick(3);
        rstn_i = 1'b1;
        run(26'h0008, 3, 6'h02);
        s_comp;
        s_ovr;
        s_stall;
        run(26'h0010, 3, 6'h28);
        run(26'h0008, 258, 6'h02);
        end_sim;
    end
endmodule // saverb_top_tb

`default_nettype wire
